// ===== src/dsr_buffer.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Same clock on both sides.
// Notes: Flags are registered so that neither side sees a combinational path.
`timescale 1ns/1ns
`default_nettype none
module dsr_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] in_data, // Word from the source
  input wire logic in_valid, // Source offers a word
  output logic in_ready, // Buffer can take a word
  output logic [WIDTH-1:0] out_data, // Oldest word
  output logic out_valid, // Oldest word is present
  input wire logic out_ready // Drain takes the word
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rd;
    logic wr;
    logic [1:0] count;
    logic full;
    logic empty;
  } dsr_buf_state_t;

  dsr_buf_state_t st_reg;
  dsr_buf_state_t st_next;

  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    st_next = st_reg;
    push = in_valid && !st_reg.full;
    pop = out_ready && !st_reg.empty;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = ~st_reg.wr;
    end
    if (pop) begin
      st_next.rd = ~st_reg.rd;
    end
    case ({push, pop})
      2'b10: st_next.count = st_reg.count + 2'h1;
      2'b01: st_next.count = st_reg.count - 2'h1;
      default: st_next.count = st_reg.count;
    endcase
    st_next.full = (st_next.count == 2'h2);
    st_next.empty = (st_next.count == 2'h0);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.empty <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready = !st_reg.full;
  assign out_valid = !st_reg.empty;
  assign out_data = st_reg.mem[st_reg.rd];

endmodule : dsr_buffer
`default_nettype wire

// ===== src/dsr_pkg.sv
// Purpose: Shared constants and types for the dual converter serial readout.
// Assumes: One 50 MHz system clock; the serial clock and select are sampled pins.
// Notes: Result words are held left-aligned in a 14-bit field for both variants.
package dsr_pkg;

  // ********************************
  // Widths and variants
  // ********************************
  localparam int RES_BITS_12 = 12;
  localparam int RES_BITS_14 = 14;
  localparam int MAX_BITS = 14;
  localparam int IN_BITS = 16;
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] CNT_MAX = 5'h1f;
  // First falling edge that launches a data bit
  localparam logic [CNT_BITS-1:0] FIRST_DATA_FALL = 5'h02;
  // Rising edges needed beyond the word width for a complete transfer
  localparam int EXTRA_RISES = 2;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int SELECT_TO_CLOCK_SETUP_NS = 15;
  localparam int SELECT_TO_CLOCK_SETUP_CYC =
    ((SELECT_TO_CLOCK_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (SELECT_TO_CLOCK_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ********************************
  // Types
  // ********************************
  typedef struct packed {
    logic [IN_BITS-1:0] positive_input_a;
    logic [IN_BITS-1:0] negative_input_a;
    logic [IN_BITS-1:0] positive_input_b;
    logic [IN_BITS-1:0] negative_input_b;
  } dsr_sample_t;

  localparam int SAMPLE_BITS = $bits(dsr_sample_t);

  typedef enum logic {
    DSR_IDLE,
    DSR_FRAME
  } dsr_phase_t;

endpackage : dsr_pkg

// ===== src/dsr_readout.sv
// Purpose: Serial result readout and frame control of a dual simultaneous converter.
// Assumes: Select and serial clock come from the host and are sampled by clk.
// Notes: Serial clock must stay well below a quarter of clk for edge detection.
// Operation
// - Results are twos-complement codes of positive minus negative input.
// - Word width is 12 or 14 bits, chosen by the variant parameter.
// - 12-bit variant clamps to 800 and 7FF hex.
// - 14-bit variant clamps to 2000 and 1FFF hex.
// - Frame runs from select falling to the next select rising.
// - Output A carries converter A, output B converter B, in parallel.
// - Select falling enables both outputs driving zero.
// - Falling edge one sends zero, then MSB to bit 0, then zeros.
// - Clock edges after the last bit give zero on both outputs.
// - Select rising releases both outputs to high impedance.
// - Sampling resumes as soon as the last bit is converted.
// - Select rising too early aborts the frame and restarts sampling.
// - Bits sent before an abort are still valid result bits.
`timescale 1ns/1ns
`default_nettype none
module dsr_readout #(
  parameter int RESULT_BITS = dsr_pkg::RES_BITS_14
) (
  input wire logic clk, // System clock, 50 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic select_n, // Frame select pin, active low
  input wire logic serial_clk, // Serial clock pin from host
  input wire dsr_pkg::dsr_sample_t sample_in, // Held inputs of both converters
  input wire logic sample_valid, // Sample word offered
  output logic sample_ready, // Sample word can be taken
  output logic result_out_a, // Serial result of converter A
  output logic result_out_a_oe, // Drive enable of output A
  output logic result_out_b, // Serial result of converter B
  output logic result_out_b_oe, // Drive enable of output B
  output logic sampling, // Sample-and-hold is tracking
  output logic frame_aborted // One-cycle pulse on a short frame
);

  // ********************************
  // Constants and helpers
  // ********************************
  localparam logic [dsr_pkg::CNT_BITS-1:0] LAST_DATA_FALL =
    dsr_pkg::CNT_BITS'(RESULT_BITS + 1);
  localparam logic [dsr_pkg::CNT_BITS-1:0] RISES_NEEDED =
    dsr_pkg::CNT_BITS'(RESULT_BITS + dsr_pkg::EXTRA_RISES);
  localparam int ALIGN = dsr_pkg::MAX_BITS - RESULT_BITS;

  typedef logic signed [dsr_pkg::IN_BITS:0] dsr_diff_t;

  // Clamp the difference to the word range, result left-aligned
  function automatic logic [dsr_pkg::MAX_BITS-1:0] dsr_code(
    input logic [dsr_pkg::IN_BITS-1:0] pos,
    input logic [dsr_pkg::IN_BITS-1:0] neg
  );
    dsr_diff_t diff;
    dsr_diff_t top;
    dsr_diff_t bottom;
    logic [dsr_pkg::MAX_BITS-1:0] code;
    diff = dsr_diff_t'({1'b0, pos}) - dsr_diff_t'({1'b0, neg});
    top = dsr_diff_t'((1 << (RESULT_BITS - 1)) - 1);
    bottom = -top - dsr_diff_t'(1);
    if (diff > top) begin
      code = top[dsr_pkg::MAX_BITS-1:0];
    end else if (diff < bottom) begin
      code = bottom[dsr_pkg::MAX_BITS-1:0];
    end else begin
      code = diff[dsr_pkg::MAX_BITS-1:0];
    end
    return dsr_pkg::MAX_BITS'(code << ALIGN);
  endfunction : dsr_code

  function automatic logic [dsr_pkg::CNT_BITS-1:0] dsr_bump(
    input logic [dsr_pkg::CNT_BITS-1:0] cnt
  );
    return (cnt == dsr_pkg::CNT_MAX) ? cnt : cnt + dsr_pkg::CNT_BITS'(1);
  endfunction : dsr_bump

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic sel_s3;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    dsr_pkg::dsr_phase_t phase;
    logic [dsr_pkg::CNT_BITS-1:0] fall_cnt;
    logic [dsr_pkg::CNT_BITS-1:0] rise_cnt;
    logic [dsr_pkg::MAX_BITS-1:0] shift_a;
    logic [dsr_pkg::MAX_BITS-1:0] shift_b;
    logic out_a;
    logic out_b;
    logic oe;
    logic track;
    logic abort;
  } dsr_state_t;

  dsr_state_t st_reg;
  dsr_state_t st_next;
  dsr_pkg::dsr_sample_t buf_data;
  logic buf_valid;
  logic buf_pop;

  // ********************************
  // Sample buffer
  // ********************************
  // Converter may run ahead by two samples while a frame is stalled
  dsr_buffer #(
    .WIDTH(dsr_pkg::SAMPLE_BITS)
  ) u_buffer (
    .clk(clk),
    .srst(srst),
    .in_data(sample_in),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(buf_pop)
  );

  // ********************************
  // Frame control
  // ********************************
  always_comb begin
    logic sel_fall;
    logic sel_rise;
    logic sck_fall;
    logic sck_rise;
    logic [dsr_pkg::CNT_BITS-1:0] falls;
    sel_fall = 1'b0;
    sel_rise = 1'b0;
    sck_fall = 1'b0;
    sck_rise = 1'b0;
    falls = '0;
    st_next = st_reg;
    buf_pop = 1'b0;
    st_next.sel_s1 = select_n;
    st_next.sel_s2 = st_reg.sel_s1;
    st_next.sel_s3 = st_reg.sel_s2;
    st_next.sck_s1 = serial_clk;
    st_next.sck_s2 = st_reg.sck_s1;
    st_next.sck_s3 = st_reg.sck_s2;
    sel_fall = st_reg.sel_s3 && !st_reg.sel_s2;
    sel_rise = !st_reg.sel_s3 && st_reg.sel_s2;
    sck_fall = st_reg.sck_s3 && !st_reg.sck_s2;
    sck_rise = !st_reg.sck_s3 && st_reg.sck_s2;
    st_next.abort = 1'b0;
    case (st_reg.phase)
      dsr_pkg::DSR_IDLE: begin
        if (sel_fall) begin
          st_next.phase = dsr_pkg::DSR_FRAME;
          st_next.oe = 1'b1;
          st_next.out_a = 1'b0;
          st_next.out_b = 1'b0;
          st_next.track = 1'b0;
          st_next.fall_cnt = '0;
          st_next.rise_cnt = '0;
          buf_pop = buf_valid;
          // Without a ready sample the frame reads as zero input
          st_next.shift_a = buf_valid ?
            dsr_code(buf_data.positive_input_a, buf_data.negative_input_a) : '0;
          st_next.shift_b = buf_valid ?
            dsr_code(buf_data.positive_input_b, buf_data.negative_input_b) : '0;
        end
      end
      dsr_pkg::DSR_FRAME: begin
        if (sel_rise) begin
          st_next.phase = dsr_pkg::DSR_IDLE;
          st_next.oe = 1'b0;
          st_next.out_a = 1'b0;
          st_next.out_b = 1'b0;
          st_next.track = 1'b1;
          st_next.abort = (st_reg.rise_cnt < RISES_NEEDED);
        end else begin
          if (sck_fall) begin
            falls = dsr_bump(st_reg.fall_cnt);
            st_next.fall_cnt = falls;
            if (falls >= dsr_pkg::FIRST_DATA_FALL) begin
              // Zeros shift in behind the word, so late edges send zero
              st_next.out_a = st_reg.shift_a[dsr_pkg::MAX_BITS-1];
              st_next.out_b = st_reg.shift_b[dsr_pkg::MAX_BITS-1];
              st_next.shift_a = {st_reg.shift_a[dsr_pkg::MAX_BITS-2:0], 1'b0};
              st_next.shift_b = {st_reg.shift_b[dsr_pkg::MAX_BITS-2:0], 1'b0};
            end
            if (falls == LAST_DATA_FALL) begin
              st_next.track = 1'b1;
            end
          end
          if (sck_rise) begin
            st_next.rise_cnt = dsr_bump(st_reg.rise_cnt);
          end
        end
      end
      default: begin
        st_next.phase = dsr_pkg::DSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.sel_s1 <= 1'b1;
      st_reg.sel_s2 <= 1'b1;
      st_reg.sel_s3 <= 1'b1;
      // Serial clock idles high, so a cleared sync would see a false edge
      st_reg.sck_s1 <= 1'b1;
      st_reg.sck_s2 <= 1'b1;
      st_reg.sck_s3 <= 1'b1;
      st_reg.phase <= dsr_pkg::DSR_IDLE;
      st_reg.track <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign result_out_a = st_reg.out_a;
  assign result_out_b = st_reg.out_b;
  assign result_out_a_oe = st_reg.oe;
  assign result_out_b_oe = st_reg.oe;
  assign sampling = st_reg.track;
  assign frame_aborted = st_reg.abort;

endmodule : dsr_readout
`default_nettype wire

// ===== tb/dsr_host_model.sv
// Purpose: Host serial master model.
// Assumes: Select and serial clock idle high.
// Notes: Captures four lines so both variants share a frame.
`timescale 1ns/1ns
`default_nettype none
module dsr_host_model (
  input wire logic go, // Start a frame
  input wire logic [5:0] rises, // Rising edges to give
  input wire logic [3:0] din, // Resolved data lines
  output logic select_n, // Select, active low
  output logic serial_clk, // Serial clock
  output logic busy, // Frame running
  output logic [3:0][15:0] cap // Captured bits
);
  // ****
  // Frame engine
  // ****
  initial begin
    select_n = 1'b1;
    serial_clk = 1'b1;
    busy = 1'b0;
    cap = '0;
  end
  always @(posedge go) begin
    busy = 1'b1;
    cap = '0;
    #13 select_n = 1'b0;
    #40;
    repeat (rises) begin
      serial_clk = 1'b0;
      #80 serial_clk = 1'b1;
      for (int i = 0; i < 4; i++) cap[i] = {cap[i][14:0], din[i]};
      #80;
    end
    select_n = 1'b1;
    #200 busy = 1'b0; // Acquisition gap
  end
endmodule : dsr_host_model
`default_nettype wire

// ===== tb/dsr_readout_monitor.sv
// Purpose: Port checker for the serial readout.
// Assumes: Pin edges reach the outputs within 3 clk.
// Notes: Bound to every readout instance.
`timescale 1ns/1ns
`default_nettype none
module dsr_readout_monitor #(
  parameter int RESULT_BITS = 14
) (
  input wire logic clk, // System clock
  input wire logic srst, // Sync reset
  input wire logic select_n, // Select pin
  input wire logic serial_clk, // Serial clock pin
  input wire logic result_out_a, // Data A
  input wire logic result_out_a_oe, // Enable A
  input wire logic result_out_b, // Data B
  input wire logic result_out_b_oe, // Enable B
  input wire logic sampling, // Tracking
  input wire logic frame_aborted // Abort pulse
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_open;
    $fell(select_n);
  endsequence
  sequence s_drive;
    ##[1:3] (result_out_a_oe && !result_out_a && !result_out_b);
  endsequence
  AST_OPEN: assert property (s_open |-> s_drive)
    else $error("no zero drive after select fell");
  AST_CLOSE: assert property ($rose(select_n) |-> ##[1:3] !result_out_a_oe)
    else $error("outputs not released");
  AST_PAIR: assert property (result_out_a_oe == result_out_b_oe)
    else $error("enables differ");
  AST_IDLE_ZERO: assert property (!result_out_a_oe |-> !result_out_a && !result_out_b)
    else $error("data while released");
  AST_LAUNCH: assert property (result_out_a_oe && $past(result_out_a_oe)
    && ($changed(result_out_a) || $changed(result_out_b)) |-> !serial_clk)
    else $error("data moved off a falling edge");
  AST_ABORT_ONE: assert property (frame_aborted |=> !frame_aborted)
    else $error("abort pulse too long");
  AST_ABORT_STATE: assert property (frame_aborted |-> !result_out_a_oe && sampling
    && $past(result_out_a_oe))
    else $error("abort state wrong");
  AST_TRACK: assert property ($fell(result_out_a_oe) |-> sampling)
    else $error("not tracking after frame");
endmodule : dsr_readout_monitor
bind dsr_readout dsr_readout_monitor #(.RESULT_BITS(RESULT_BITS)) u_mon (.clk(clk), .srst(srst),
  .select_n(select_n), .serial_clk(serial_clk), .result_out_a(result_out_a),
  .result_out_a_oe(result_out_a_oe), .result_out_b(result_out_b),
  .result_out_b_oe(result_out_b_oe), .sampling(sampling), .frame_aborted(frame_aborted));
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for both readout variants.
// Assumes: One host frames both instances together.
// Notes: Index 0 is the 14-bit instance, 1 the 12-bit one.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {
    dsr_pkg::dsr_sample_t s;
    logic [13:0] a14;
    logic [13:0] b14;
    logic [11:0] a12;
    logic [11:0] b12;
  } dsr_row_t;
  dsr_row_t rows [4];
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sample_valid = 1'b0;
  dsr_pkg::dsr_sample_t sample_in = '0;
  logic go = 1'b0;
  logic clr = 1'b0;
  logic [5:0] rises = 6'h10;
  logic [1:0] seen_ab = 2'h0;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int rise_no = 0;
  logic [3:0] trk = 4'h0;
  wire logic select_n, serial_clk, busy;
  wire logic [3:0][15:0] cap;
  wire logic [1:0] oa, ob, oea, oeb, smp, abt, rdy;
  wire logic [3:0] din = {oeb[1] ? ob[1] : 1'bz, oea[1] ? oa[1] : 1'bz,
    oeb[0] ? ob[0] : 1'bz, oea[0] ? oa[0] : 1'bz};
  for (genvar g = 0; g < 2; g++) begin : g_dut
    dsr_readout #(.RESULT_BITS(g ? 12 : 14)) uut (.clk(clk), .srst(srst), .select_n(select_n),
      .serial_clk(serial_clk), .sample_in(sample_in), .sample_valid(sample_valid),
      .sample_ready(rdy[g]), .result_out_a(oa[g]), .result_out_a_oe(oea[g]),
      .result_out_b(ob[g]), .result_out_b_oe(oeb[g]), .sampling(smp[g]), .frame_aborted(abt[g]));
  end
  dsr_host_model host (.go(go), .rises(rises), .din(din), .select_n(select_n),
    .serial_clk(serial_clk), .busy(busy), .cap(cap));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    seen_ab <= clr ? 2'h0 : seen_ab | abt;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // Sampling seen at the rise before and after the last data launch
  always @(posedge serial_clk or posedge select_n) begin
    if (select_n) begin
      rise_no <= 0;
    end else begin
      rise_no <= rise_no + 1;
      case (rise_no)
        11: trk[2] <= smp[1];
        12: trk[3] <= smp[1];
        13: trk[0] <= smp[0];
        14: trk[1] <= smp[0];
        default: ;
      endcase
    end
  end
  // ****
  // Tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic frame(input logic [5:0] n);
    rises <= n;
    go <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    clr <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
  endtask : frame
  task automatic full(input dsr_row_t w);
    frame(6'h10);
    check(cap[0], {1'b0, w.a14, 1'b0});
    check(cap[1], {1'b0, w.b14, 1'b0});
    check(cap[2], {1'b0, w.a12, 3'h0});
    check(cap[3], {1'b0, w.b12, 3'h0});
    check(seen_ab, 2'h0);
    check(trk, 4'ha);
  endtask : full
  // ****
  // Sequence
  // ****
  initial begin
    rows[0] = {64'h1000_1000_1000_1001, 14'h0000, 14'h3fff, 12'h000, 12'hfff};
    rows[1] = {64'hffff_0000_0000_ffff, 14'h1fff, 14'h2000, 12'h7ff, 12'h800};
    rows[2] = {64'h0345_0000_0000_1fff, 14'h0345, 14'h2001, 12'h345, 12'h800};
    rows[3] = {64'h0000_2000_1fff_0000, 14'h2000, 14'h1fff, 12'h800, 12'h7ff};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check(oea, 2'h0);
    check(smp, 2'h3);
    check(rdy, 2'h3);
    $display("reset test done");
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      sample_in <= rows[r].s;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      full(rows[r]);
      $display("row %0d test done", r);
    end
    // Three offers against a receiver that stalls: third is refused
    for (int r = 0; r < 3; r++) begin
      sample_in <= rows[r].s;
      sample_valid <= 1'b1;
      @(posedge clk);
    end
    @(posedge clk);
    sample_valid <= 1'b0;
    #1 check(rdy, 2'h0);
    full(rows[0]);
    full(rows[1]);
    check(rdy, 2'h3);
    frame(6'h10);
    for (int k = 0; k < 4; k++) check(cap[k], 16'h0);
    $display("buffer test done");
    sample_in <= rows[2].s;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    frame(6'h0f);
    check(seen_ab, 2'h1);
    check(cap[0], {1'b0, rows[2].a14, 1'b0} >> 1);
    check(cap[3], {1'b0, rows[2].b12, 2'h0});
    check(smp, 2'h3);
    $display("abort test done");
    frame(6'h0e);
    check(seen_ab, 2'h1);
    frame(6'h0d);
    check(seen_ab, 2'h3);
    $display("short frame test done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
